// File: include/sse_pkg.sv
// Constants, register map and types for the SPI shift-exchange port
package sse_pkg;

  // ************************************************************
  // Data and bus widths
  // ************************************************************
  localparam int unsigned SSE_DW   = 8;   // Shift register width
  localparam int unsigned SSE_AW   = 8;   // Decoded byte-address bits
  localparam int unsigned SSE_NSEL = 4;   // Select outputs in master role
  localparam int unsigned SSE_SYNW = 3;   // Pins passed through the synchroniser

  // ************************************************************
  // Register byte addresses
  // ************************************************************
  localparam logic [SSE_AW-1:0] SSE_A_CTRL = 8'h00;
  localparam logic [SSE_AW-1:0] SSE_A_STAT = 8'h04;
  localparam logic [SSE_AW-1:0] SSE_A_DATA = 8'h08;
  localparam logic [SSE_AW-1:0] SSE_A_SEL  = 8'h0C;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int unsigned SSE_CTRL_EN   = 0;  // Port enable
  localparam int unsigned SSE_CTRL_MST  = 1;  // 1 = master role
  localparam int unsigned SSE_CTRL_CKP  = 2;  // Idle level of the serial clock
  localparam int unsigned SSE_CTRL_CKE  = 3;  // 1 = drive on trailing edge
  localparam int unsigned SSE_CTRL_DIV  = 8;  // Half-period divider, lsb
  localparam int unsigned SSE_DIV_W     = 8;
  localparam int unsigned SSE_CTRL_W    = 16;
  localparam logic [SSE_CTRL_W-1:0] SSE_CTRL_RST = 16'h0400;

  localparam int unsigned SSE_STAT_DONE = 0;  // Transfer done flag, W1C
  localparam int unsigned SSE_STAT_WRITE_COLLISION_FLAG = 1;  // Write collision flag, W1C
  localparam int unsigned SSE_STAT_BF   = 2;  // Receive buffer full
  localparam int unsigned SSE_STAT_BUSY = 3;  // Exchange in progress

  localparam int unsigned SSE_SEL_EN    = 2;  // Select line active
  localparam int unsigned SSE_SEL_W     = 3;
  localparam logic [SSE_SEL_W-1:0] SSE_SEL_RST = 3'h0;

  // ************************************************************
  // Counts and bus codes
  // ************************************************************
  localparam logic [2:0] SSE_BIT_LAST = 3'h7;  // Eighth sampled bit
  localparam logic [3:0] SSE_TOG_LAST = 4'hF;  // Sixteenth clock toggle
  localparam logic [1:0] SSE_HTRANS_NONSEQ = 2'h2;

  // ************************************************************
  // Exchange state
  // ************************************************************
  typedef enum logic [0:0] {SSE_IDLE, SSE_SHIFT} sse_state_t;

endpackage : sse_pkg

// File: logic/sse_sync.sv
// Two-flop synchroniser for pins sampled by the system clock
`timescale 1ns/1ps
module sse_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Asynchronous input and its synchronised copy
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : sse_sync

// File: logic/sse_port.sv
// SPI shift-exchange port with AHB-Lite register access
`timescale 1ns/1ps

// Overview of operation
// (R1) Eight-bit shift register on each side
// (R2) Shift out MSb first, LSb in
// (R3) Drive one edge, sample the opposite
// (R4) Master out to slave in, and back
// (R5) Only the master generates the clock
// (R6) Both sides share the clock polarity
// (R7) Slave stores master MSb at LSb first
// (R8) Eight clocks swap both registers fully
// (R9) More data: reload and repeat exchange
// (R10) Master stops clock, then deselects
// (R11) Unselected slave ignores bus, stays silent
// (R12) At most one select asserted at once
// (R13) One select output per slave
// (R14) Unselected slave output is high impedance
// (R15) Only master initiates, select enables slave
// (R16) Select idles high, falling starts transmission
// (R17) Full byte to buffer, set done flag
// (R18) Busy write discarded, collision flag set
// (R19) Master starts clocking on buffer write
// (R20) Idle clock held at polarity level
// (R21) Deselect resets slave bit counter
module sse_port (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  // AHB-Lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic      [31:0]                   hrdata,
  // Serial clock pin
  input  wire logic                          sck_i,
  output logic                               sck_o,
  output logic                               sck_oe,
  // Serial data pins
  input  wire logic                          sdi_i,
  output logic                               sdo_o,
  output logic                               sdo_oe,
  // Select lines, active low
  input  wire logic                          ss_in_b,
  output logic      [sse_pkg::SSE_NSEL-1:0]  ss_out_b
);
  import sse_pkg::*;

  // ************************************************************
  // Pin synchronisation
  // ************************************************************
  logic [SSE_SYNW-1:0] pins_s;
  logic                sck_s;
  logic                sdi_s;
  logic                ss_b_s;
  logic                sck_q_r;
  logic                ss_q_r;

  sse_sync #(
    .W        (SSE_SYNW)
  ) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in ({sck_i, sdi_i, ss_in_b}),
    .sync_out (pins_s)
  );

  assign sck_s  = pins_s[2];
  assign sdi_s  = pins_s[1];
  assign ss_b_s = pins_s[0];

  // ************************************************************
  // Register state
  // ************************************************************
  logic [SSE_CTRL_W-1:0] ctrl_r;
  logic [SSE_SEL_W-1:0]  sel_r;
  logic                  done_r;
  logic                  write_collision_flag_r;
  logic                  bf_r;
  logic [SSE_DW-1:0]     rxbuf_r;
  logic [SSE_DW-1:0]     sr_r;
  logic                  sdo_r;
  logic [2:0]            cnt_r;
  logic [3:0]            tog_r;
  logic [SSE_DIV_W-1:0]  hcnt_r;
  logic                  sck_r;
  sse_state_t            state_r;
  sse_state_t            state_nxt;
  logic                  wr_r;
  logic [SSE_AW-1:0]     waddr_r;
  logic [31:0]           rdata_r;

  // Control fields
  logic                  en;
  logic                  mst;
  logic                  ckp;
  logic                  cke;
  logic [SSE_DIV_W-1:0]  div;
  assign en  = ctrl_r[SSE_CTRL_EN];
  assign mst = ctrl_r[SSE_CTRL_MST];
  assign ckp = ctrl_r[SSE_CTRL_CKP];
  assign cke = ctrl_r[SSE_CTRL_CKE];
  assign div = ctrl_r[SSE_CTRL_DIV +: SSE_DIV_W];

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic              acc;
  logic              rd_data_ev;
  logic              wr_ctrl;
  logic              wr_stat;
  logic              wr_data;
  logic              wr_sel;
  logic              busy;
  logic              wr_load;
  logic              wr_coll;
  logic [31:0]       rd_mux;

  // Address phase is taken when the bus is ready and the slot is NONSEQ
  assign acc        = hsel & hready & (htrans == SSE_HTRANS_NONSEQ);
  assign rd_data_ev = acc & ~hwrite & (haddr[SSE_AW-1:0] == SSE_A_DATA);
  assign wr_ctrl    = wr_r & (waddr_r == SSE_A_CTRL);
  assign wr_stat    = wr_r & (waddr_r == SSE_A_STAT);
  assign wr_data    = wr_r & (waddr_r == SSE_A_DATA);
  assign wr_sel     = wr_r & (waddr_r == SSE_A_SEL);
  assign busy       = (state_r == SSE_SHIFT);
  assign wr_load    = wr_data & ~busy;
  assign wr_coll    = wr_data & busy;                     // [R18]

  // Read mux; unmapped offsets read as zero
  assign rd_mux =
    (haddr[SSE_AW-1:0] == SSE_A_CTRL) ? {16'h0000, ctrl_r} :
    (haddr[SSE_AW-1:0] == SSE_A_STAT) ? {28'h0000000, busy, bf_r, write_collision_flag_r, done_r} :
    (haddr[SSE_AW-1:0] == SSE_A_DATA) ? {24'h000000, rxbuf_r} :
    (haddr[SSE_AW-1:0] == SSE_A_SEL)  ? {29'h00000000, sel_r} : 32'h00000000;

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;

  // Address phase capture; read data is latched here for the data phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_r    <= 1'b0;
      waddr_r <= '0;
      rdata_r <= 32'h00000000;
    end else begin
      wr_r    <= acc & hwrite;
      waddr_r <= acc ? haddr[SSE_AW-1:0] : waddr_r;
      rdata_r <= (acc & ~hwrite) ? rd_mux : rdata_r;
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= SSE_CTRL_RST;
      sel_r  <= SSE_SEL_RST;
    end else begin
      ctrl_r <= wr_ctrl ? hwdata[SSE_CTRL_W-1:0] : ctrl_r;   // [R6]
      sel_r  <= wr_sel ? hwdata[SSE_SEL_W-1:0] : sel_r;
    end
  end

  // ************************************************************
  // Clock edge events
  // ************************************************************
  logic ss_sel;
  logic ss_fall;
  logic s_lead;
  logic s_trail;
  logic m_tick;
  logic lead;
  logic trail;
  logic samp_ev;
  logic drv_ev;
  logic done_ev;
  logic [SSE_DW-1:0] sr_shift;

  // Slave logic sees the bus only while its select is low
  assign ss_sel  = ~ss_b_s & en & ~mst;                   // [R11]
  assign ss_fall = ss_sel & ss_q_r;                       // [R16]
  assign s_lead  = ss_sel & (ckp ? (~sck_s & sck_q_r) : (sck_s & ~sck_q_r));
  assign s_trail = ss_sel & (ckp ? (sck_s & ~sck_q_r) : (~sck_s & sck_q_r));
  // Master edges come from the own divider, never from the pin
  assign m_tick  = busy & mst & (hcnt_r == div);          // [R5]
  assign lead    = mst ? (m_tick & (sck_r == ckp)) : s_lead;
  assign trail   = mst ? (m_tick & (sck_r != ckp)) : s_trail;
  assign samp_ev = cke ? lead : trail;                    // [R3]
  assign drv_ev  = cke ? trail : lead;                    // [R3]
  assign done_ev = samp_ev & (cnt_r == SSE_BIT_LAST);     // [R8]
  assign sr_shift = {sr_r[SSE_DW-2:0], sdi_s};            // [R2] [R7]

  // Edge detect history; reads the synchronised copies only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_q_r <= 1'b0;
      ss_q_r  <= 1'b1;                                    // Idle means not selected
    end else begin
      sck_q_r <= sck_s;
      ss_q_r  <= ~ss_sel;
    end
  end

  // ************************************************************
  // Exchange sequencing
  // ************************************************************
  // Slave leaves the shift state when deselected mid-byte
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SSE_IDLE: begin
        if (en & mst & wr_load) begin
          state_nxt = SSE_SHIFT;                          // [R19]
        end else if (~mst & samp_ev) begin
          state_nxt = SSE_SHIFT;
        end
      end
      SSE_SHIFT: begin
        if (~en) begin
          state_nxt = SSE_IDLE;
        end else if (mst & m_tick & (tog_r == SSE_TOG_LAST)) begin
          state_nxt = SSE_IDLE;                           // [R10]
        end else if (~mst & (done_ev | ~ss_sel)) begin
          state_nxt = SSE_IDLE;
        end
      end
      default: state_nxt = SSE_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= SSE_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Master clock divider and toggle count; idle level follows polarity
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hcnt_r <= '0;
      tog_r  <= 4'h0;
      sck_r  <= 1'b0;
    end else begin
      hcnt_r <= (~busy | m_tick) ? '0 : hcnt_r + 1'b1;
      tog_r  <= ~busy ? 4'h0 : (m_tick ? tog_r + 4'h1 : tog_r);
      if (~busy | ~mst) begin
        sck_r <= ckp;                                     // [R20]
      end else if (m_tick) begin
        sck_r <= ~sck_r;
      end
    end
  end

  // Shift register: loaded by a write, shifted on each sample edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sr_r <= '0;
    end else if (wr_load) begin
      sr_r <= hwdata[SSE_DW-1:0];                         // [R9]
    end else if (samp_ev) begin
      sr_r <= sr_shift;                                   // [R1] [R2]
    end
  end

  // Bit counter, cleared whenever the slave is not selected
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 3'h0;
    end else if (~mst & ~ss_sel) begin
      cnt_r <= 3'h0;                                      // [R21]
    end else if (wr_load) begin
      cnt_r <= 3'h0;
    end else if (samp_ev) begin
      cnt_r <= cnt_r + 3'h1;                              // Wraps after eight
    end
  end

  // Outgoing bit: preloaded so a trailing-edge mode is valid early
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sdo_r <= 1'b0;
    end else if (wr_load) begin
      sdo_r <= hwdata[SSE_DW-1];
    end else if (ss_fall) begin
      sdo_r <= sr_r[SSE_DW-1];
    end else if (drv_ev) begin
      sdo_r <= sr_r[SSE_DW-1];                            // [R2] [R4]
    end
  end

  // ************************************************************
  // Status flags; hardware set wins over software clear
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_r  <= 1'b0;
      write_collision_flag_r  <= 1'b0;
      bf_r    <= 1'b0;
      rxbuf_r <= '0;
    end else begin
      done_r <= done_ev | (done_r & ~(wr_stat & hwdata[SSE_STAT_DONE]));  // [R17]
      write_collision_flag_r <= wr_coll | (write_collision_flag_r & ~(wr_stat & hwdata[SSE_STAT_WRITE_COLLISION_FLAG]));  // [R18]
      bf_r   <= done_ev | (bf_r & ~rd_data_ev);
      if (done_ev) begin
        rxbuf_r <= sr_shift;                              // [R17]
      end
    end
  end

  // ************************************************************
  // Pin drivers
  // ************************************************************
  logic [SSE_NSEL-1:0] sel_onehot;
  // One decoded line only, so two slaves can never be selected together
  assign sel_onehot = (SSE_NSEL'(1) << sel_r[1:0]);
  assign ss_out_b   = ~(sel_onehot & {SSE_NSEL{sel_r[SSE_SEL_EN] & en & mst}});
  assign sck_o      = sck_r;
  assign sck_oe     = en & mst;
  assign sdo_o      = sdo_r;
  assign sdo_oe     = en & (mst | ss_sel);                // [R14]

  // ************************************************************
  // Checks
  // ************************************************************
  property p_start;
    @(posedge clk) disable iff (!rst_b)
      (en & mst & wr_data & ~busy) |=> busy ##1 (hcnt_r == 8'h01 || m_tick);
  endproperty
  a_start: assert property (p_start) else $error("master did not start"); // [R19]

  property p_coll;
    @(posedge clk) disable iff (!rst_b)
      wr_data & busy & ~samp_ev |=> write_collision_flag_r && $stable(sr_r);
  endproperty
  a_coll: assert property (p_coll) else $error("busy write not discarded"); // [R18]

  property p_done;
    @(posedge clk) disable iff (!rst_b)
      done_ev |=> done_r && bf_r && (rxbuf_r == $past(sr_shift));
  endproperty
  a_done: assert property (p_done) else $error("byte not moved to buffer"); // [R17]

  property p_shift;
    @(posedge clk) disable iff (!rst_b)
      samp_ev & ~wr_load |=> sr_r == {$past(sr_r[6:0]), $past(sdi_s)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift lost a bit"); // [R2]

  property p_eight;
    @(posedge clk) disable iff (!rst_b)
      done_ev |-> cnt_r == SSE_BIT_LAST ##1 cnt_r == 3'h0;
  endproperty
  a_eight: assert property (p_eight) else $error("byte not eight bits"); // [R8]

  property p_quiet;
    @(posedge clk) disable iff (!rst_b)
      (en & ~mst & ss_b_s) |-> ~sdo_oe ##1 ~s_lead & ~s_trail;
  endproperty
  a_quiet: assert property (p_quiet) else $error("unselected slave drives"); // [R14]

  property p_ignore;
    @(posedge clk) disable iff (!rst_b)
      (~mst & ~ss_sel & ~wr_load) |=> $stable(sr_r) && cnt_r == 3'h0;
  endproperty
  a_ignore: assert property (p_ignore) else $error("unselected slave shifted"); // [R11]

  property p_idle_clk;
    @(posedge clk) disable iff (!rst_b)
      (mst & ~busy) [*2] |-> sck_o == $past(ckp);
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("clock off idle level"); // [R20]

  property p_edges;
    @(posedge clk) disable iff (!rst_b)
      samp_ev |-> ~drv_ev;
  endproperty
  a_edges: assert property (p_edges) else $error("drive and sample coincide"); // [R3]

endmodule : sse_port

// File: bench/sse_far_end.sv
// Far-side SPI party: slave to the port in master role, master otherwise
`timescale 1ns/1ps
module sse_far_end (
  // System clock and port outputs
  input  wire logic                         clk,
  input  wire logic                         sck_o,
  input  wire logic                         sck_oe,
  input  wire logic                         sdo_o,
  input  wire logic                         sdo_oe,
  input  wire logic [sse_pkg::SSE_NSEL-1:0] ss_out_b,
  // Port inputs
  output logic                              sck_i,
  output logic                              sdi_i,
  output logic                              ss_in_b
);
  import sse_pkg::*;
  // ************************************************************
  // Settings from the bench and model state
  // ************************************************************
  logic            ckp = 1'b0, cke = 1'b0, mrole = 1'b0, p_sck = 1'b0;
  logic            m_bit = 1'b0, unsel = 1'b0;
  logic            ss_b = 1'b1;  // Idles high between frames
  logic [1:0]      idx = 2'h0;
  logic [7:0]      s_tx = 8'h00, s_rx = 8'h00, sh = 8'h00;
  logic [2:0]      d = 3'h0, n = 3'h0;
  int              oe_bad = 0;
  wire logic       sck_w = sck_oe ? sck_o : p_sck;
  wire logic       sdo_w = sdo_oe ? sdo_o : 1'bz;
  wire logic       sel = mrole & ~ss_out_b[idx];  // Watches one select
  wire logic [2:0] bi = cke ? 3'h7 - d : 3'h0 - d;  // MSb first

  // Idle data line shows the inverse of its last bit
  assign sck_i = sck_w;
  assign ss_in_b = ss_b;
  assign sdi_i = mrole ? (sel ? s_tx[bi] : ~s_tx[bi]) : m_bit;

  // Slave side: drive on one edge, sample on the other
  always @(sck_w) begin
    if (sel) begin
      if ((sck_w !== ckp) ^ cke) begin
        d = d + 3'h1;
      end else begin
        sh = {sh[6:0], sdo_w};
        n = n + 3'h1;
        if (n == 3'h0) begin
          s_rx = sh;  // Next byte follows in the same frame
        end
      end
    end
  end

  // New selection restarts both counts
  always @(sel) begin
    d = 3'h0;
    n = 3'h0;
  end

  // Drive of the data pin during a frame sent with select held off
  always @(posedge clk) begin
    if (unsel && sdo_oe) begin
      oe_bad++;
    end
  end

  // Master clock at 125 ns per bit; clock stands still outside frames
  task automatic xfer(input logic [7:0] tx, input int nb, input logic sl,
                      output logic [7:0] rx);
    rx = 8'h00;
    unsel = ~sl;
    ss_b = ~sl;  // Select alone enables the slave
    m_bit = tx[7];
    #100;
    for (int i = 0; i < nb; i++) begin
      p_sck = ~ckp;  // Only this side makes the clock
      rx = cke ? {rx[6:0], sdo_w} : rx;
      m_bit = cke ? m_bit : tx[7-i];
      #62.5;
      p_sck = ckp;
      rx = cke ? rx : {rx[6:0], sdo_w};
      m_bit = (cke && i < 7) ? tx[6-i] : m_bit;
      #62.5;
    end
    #100;
    ss_b = 1'b1;  // Clock stopped, then deselect
    unsel = 1'b0;
    m_bit = ~m_bit;
    #200;
  endtask : xfer
endmodule : sse_far_end

// File: bench/test_sse_port.sv
// Self-checking bench for the SPI shift-exchange port
`timescale 1ns/1ps
module test_sse_port;
  import sse_pkg::*;
  // ************************************************************
  // Signals
  // ************************************************************
  logic                clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]          htrans = 2'h0;
  logic [2:0]          hsize = 3'h2;  // Whole words only
  logic [31:0]         haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic                hready, hreadyout, hresp, sck_o, sck_oe, sdo_o, sdo_oe;
  logic                sck_i, sdi_i, ss_in_b;
  logic [SSE_NSEL-1:0] ss_out_b;
  logic [7:0]          rx;
  int                  fail_count = 0, checks = 0, m;

  assign hready = hreadyout;  // Single slave on the bus

  sse_port i_dut (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sck_i(sck_i),
    .sck_o(sck_o), .sck_oe(sck_oe), .sdi_i(sdi_i), .sdo_o(sdo_o),
    .sdo_oe(sdo_oe), .ss_in_b(ss_in_b), .ss_out_b(ss_out_b)
  );
  sse_far_end i_far (
    .clk(clk), .sck_o(sck_o), .sck_oe(sck_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .ss_out_b(ss_out_b), .sck_i(sck_i), .sdi_i(sdi_i), .ss_in_b(ss_in_b)
  );

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Single AHB-Lite transfer; each phase waits for hready, bounded
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= SSE_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (hready !== 1'b1 && n < 50);
      if (n >= 50) begin
        fail_count++;
        wrap_up();
      end
      if (p == 0) begin
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
      end
    end
    // Writes land at the closing edge; compare only once they have settled
    #1;
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(nm, exp, rd);
  endtask : rchk

  // Polls status until done is set and the exchange has ended
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      bus(SSE_A_STAT, 1'b0, 32'h0);
      n++;
    end while (!(rd[SSE_STAT_DONE] === 1'b1 && rd[SSE_STAT_BUSY] === 1'b0) && n < 400);
    if (n >= 400) begin
      fail_count++;
      wrap_up();
    end
  endtask : wait_done

  // ************************************************************
  // Clock and main sequence
  // ************************************************************
  initial begin
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values and an unmapped place
    rchk("ctrl", SSE_A_CTRL, 32'h0000_0400);
    rchk("stat", SSE_A_STAT, 32'h0);
    rchk("sel", SSE_A_SEL, 32'h0);
    bus(8'h10, 1'b1, 32'hFFFF_FFFF);
    rchk("unmapped", 8'h10, 32'h0);
    chk("ss idle", 32'hF, {28'h0, ss_out_b});
    // Master role in all four clock modes, two bytes per frame
    for (m = 0; m < 4; m++) begin
      i_far.ckp = m[0];
      i_far.cke = m[1];
      i_far.mrole = 1'b1;
      i_far.idx = m[1:0];
      bus(SSE_A_CTRL, 1'b1, 32'h0403 | (m << 2));
      rchk("ctrl rw", SSE_A_CTRL, 32'h0403 | (m << 2));
      chk("sck idle", {31'h0, m[0]}, {31'h0, sck_o});
      bus(SSE_A_SEL, 1'b1, 32'h4 | m);
      chk("one select", ~(32'h1 << m) & 32'hF, {28'h0, ss_out_b});
      i_far.s_tx = 8'h3C ^ 8'(m);
      bus(SSE_A_DATA, 1'b1, 32'hA5 + m);
      bus(SSE_A_DATA, 1'b1, 32'h00);
      wait_done();
      rchk("stat flags", SSE_A_STAT, 32'h7);
      rchk("master rx", SSE_A_DATA, 32'h3C ^ m);
      chk("far rx", 32'hA5 + m, {24'h0, i_far.s_rx});
      bus(SSE_A_STAT, 1'b1, 32'h3);
      rchk("stat clear", SSE_A_STAT, 32'h0);
      i_far.s_tx = 8'h96;
      bus(SSE_A_DATA, 1'b1, 32'h69);
      wait_done();
      rchk("second rx", SSE_A_DATA, 32'h96);
      chk("second far rx", 32'h69, {24'h0, i_far.s_rx});
      chk("sck stop", {31'h0, m[0]}, {31'h0, sck_o});
      bus(SSE_A_SEL, 1'b1, 32'h0);
      chk("deselect", 32'hF, {28'h0, ss_out_b});
      bus(SSE_A_STAT, 1'b1, 32'h3);
    end
    // Slave role: foreign traffic, aborted byte, then a full byte
    for (m = 0; m < 4; m++) begin
      i_far.mrole = 1'b0;
      i_far.ckp = m[0];
      i_far.cke = m[1];
      i_far.p_sck = m[0];
      bus(SSE_A_CTRL, 1'b1, 32'h0401 | (m << 2));
      chk("no clock out", 32'h0, {31'h0, sck_oe});
      i_far.xfer(8'hFF, 8, 1'b0, rx);
      chk("quiet oe", 32'h0, i_far.oe_bad);
      i_far.xfer(8'h0F, 4, 1'b1, rx);
      bus(SSE_A_DATA, 1'b1, 32'hC3 ^ m);
      i_far.xfer(8'h5A + 8'(m), 8, 1'b1, rx);
      wait_done();
      rchk("slave stat", SSE_A_STAT, 32'h5);
      rchk("slave rx", SSE_A_DATA, 32'h5A + m);
      chk("far master rx", 32'hC3 ^ m, {24'h0, rx});
      bus(SSE_A_STAT, 1'b1, 32'h3);
    end
    wrap_up();
  end
endmodule : test_sse_port
